// >>> fprf_pkg.sv
`default_nettype none
// -----------------------------------------------------------------------------
// shared constants and types
// -----------------------------------------------------------------------------
package fprf_pkg;

  // rounding mode select encodings; codes 6 and 7 are illegal
  typedef enum logic [2:0] {
    FPRF_RND_NEAR_EVEN = 3'h0,
    FPRF_RND_MINUS     = 3'h1,
    FPRF_RND_PLUS      = 3'h2,
    FPRF_RND_ZERO      = 3'h3,
    FPRF_RND_NEAR_MAG  = 3'h4,
    FPRF_RND_AWAY      = 3'h5
  } fprf_mode_type;

  // destination formats
  typedef enum logic [2:0] {
    FPRF_IEEE_S = 3'h0,
    FPRF_IEEE_D = 3'h1,
    FPRF_B16_S  = 3'h2,
    FPRF_B16_D  = 3'h3,
    FPRF_ALT_F  = 3'h4,
    FPRF_ALT_D  = 3'h5,
    FPRF_ALT_G  = 3'h6,
    FPRF_INT    = 3'h7
  } fprf_fmt_type;

  // per format, indexed by format code: ieee s/d, b16 s/d, alt f/d/g, int
  localparam logic [6:0] FPRF_NBITS [8] =
    '{7'h18, 7'h35, 7'h18, 7'h38, 7'h18, 7'h38, 7'h35, 7'h20};
  localparam logic [6:0] FPRF_EXP_POS [8] =
    '{7'h17, 7'h34, 7'h18, 7'h38, 7'h17, 7'h37, 7'h34, 7'h00};
  localparam logic [6:0] FPRF_EXP_WID [8] =
    '{7'h08, 7'h0b, 7'h07, 7'h07, 7'h08, 7'h08, 7'h0b, 7'h00};
  localparam logic [6:0] FPRF_SIGN_POS [8] =
    '{7'h1f, 7'h3f, 7'h1f, 7'h3f, 7'h1f, 7'h3f, 7'h3f, 7'h1f};
  localparam logic signed [14:0] FPRF_BIAS [8] =
    '{15'sh007f, 15'sh03ff, 15'sh0040, 15'sh0040,
      15'sh0081, 15'sh0081, 15'sh0401, 15'sh0000};
  localparam logic signed [14:0] FPRF_EMAX [8] =
    '{15'sh00fe, 15'sh07fe, 15'sh007f, 15'sh007f,
      15'sh00ff, 15'sh00ff, 15'sh07ff, 15'sh0000};
  localparam logic signed [14:0] FPRF_EMIN [8] =
    '{15'sh0001, 15'sh0001, 15'sh0000, 15'sh0000,
      15'sh0001, 15'sh0001, 15'sh0001, 15'sh0000};
  // exponent wrap for trapped ieee overflow
  localparam logic signed [14:0] FPRF_WRAP_S = 15'sh00c0;
  localparam logic signed [14:0] FPRF_WRAP_D = 15'sh0600;

endpackage : fprf_pkg

`default_nettype wire

// >>> fprf_round_inc.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// rounding decision and increment
// -----------------------------------------------------------------------------
module fprf_round_inc
  import fprf_pkg::*;
(
  input  wire logic [2:0]  round_mode_i,
  input  wire logic        sign_i,
  input  wire logic        lsb_i,
  input  wire logic        round_bit_i,
  input  wire logic        sticky_i,
  input  wire logic [56:0] sig_i,
  output logic      [57:0] sum_o,
  output logic             inc_o,
  output logic             inexact_o
);

  // increment decision, one arm per mode
  always_comb
  begin
    inexact_o = round_bit_i | sticky_i;
    unique case (round_mode_i)
      FPRF_RND_NEAR_EVEN: inc_o = round_bit_i & (sticky_i | lsb_i);
      FPRF_RND_MINUS:     inc_o = sign_i & inexact_o;
      FPRF_RND_PLUS:      inc_o = ~sign_i & inexact_o;
      FPRF_RND_ZERO:      inc_o = 1'b0;
      FPRF_RND_NEAR_MAG:  inc_o = round_bit_i;
      FPRF_RND_AWAY:      inc_o = inexact_o;
      default:            inc_o = 1'b0;  // illegal code truncates
    endcase
    sum_o = {1'b0, sig_i} + {57'h0, inc_o};
  end

endmodule : fprf_round_inc

`default_nettype wire

// >>> fprf_round_format.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Each operation carries one of six rounding modes on round_mode_select, applied to floating results and integer products alike.
// - Nearest-even mode rounds to the closest value and sends an exact tie to the even neighbour.
// - Toward-minus mode delivers the closest value not above the exact result.
// - Toward-plus mode delivers the closest value not below the exact result.
// - Toward-zero mode delivers the closest value whose magnitude does not exceed the exact one.
// - Nearest-magnitude mode rounds to the closest value and sends an exact tie to the larger magnitude.
// - Away-from-zero mode delivers the closest value whose magnitude is at least the exact one.
// - Every rounding mode is accepted with every number format.
// - An overflowing ieee operation returns its result in the selected destination format at that format's precision.
// - A trapped overflow narrowing to single gives a single result with wrapped single exponent plus overflow and inexact flags.
// - The base-16 double word is sign, a 7-bit exponent biased by 64 and a 56-bit fraction.
// - Base-16 sign 0 is positive, 1 negative, and a true zero is always positive.
// - Alternate D words hold sign 63, exponent 62-55, fraction 54-0; G words exponent 62-52, fraction 51-0.
module fprf_round_format
  import fprf_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  input  wire logic               valid_i,
  input  wire logic [2:0]         round_mode_select_i,
  input  wire logic [2:0]         format_i,
  input  wire logic               sign_i,
  input  wire logic               zero_i,
  input  wire logic signed [12:0] exp_i,
  input  wire logic [63:0]        mant_i,
  input  wire logic               sticky_i,
  input  wire logic               trap_enable_i,
  output logic                    valid_o,
  output logic [63:0]             result_o,
  output logic                    overflow_o,
  output logic                    underflow_o,
  output logic                    inexact_o,
  output logic                    illegal_mode_o
);

  // ---------------------------------------------------------------------------
  // significand split
  // ---------------------------------------------------------------------------
  logic [6:0]         nb;
  logic [63:0]        kept;
  logic [63:0]        rest;
  logic [56:0]        sig;
  logic               rnd;
  logic               stk;
  logic [57:0]        sum;
  logic               inc;
  logic               rnd_inexact;

  // keep the top nb bits, everything below feeds round and sticky
  always_comb
  begin
    nb   = FPRF_NBITS[format_i];
    kept = mant_i >> (7'h40 - nb);
    rest = mant_i << nb;
    sig  = kept[56:0];
    rnd  = rest[63];
    stk  = (|rest[62:0]) | sticky_i;
  end

  // mode applies to any format, the integer path included
  fprf_round_inc u_round_inc (
    .round_mode_i (round_mode_select_i),
    .sign_i       (sign_i),
    .lsb_i        (sig[0]),
    .round_bit_i  (rnd),
    .sticky_i     (stk),
    .sig_i        (sig),
    .sum_o        (sum),
    .inc_o        (inc),
    .inexact_o    (rnd_inexact)
  );

  // ---------------------------------------------------------------------------
  // renormalise, bias and pack
  // ---------------------------------------------------------------------------
  logic [57:0]        carry_vec;
  logic               carry;
  logic               is_b16;
  logic               is_ieee;
  logic [57:0]        mfin;
  logic signed [14:0] eb;
  logic [63:0]        fmask;
  logic [63:0]        frac;
  logic [63:0]        emask;
  logic [63:0]        sbit;
  logic               away;
  logic [31:0]        int_mag;
  logic [63:0]        next_result;
  logic               next_overflow;
  logic               next_underflow;
  logic               next_inexact;
  logic               next_illegal;
  logic               next_valid;

  // place exponent field and fraction under the sign bit
  function automatic logic [63:0] fprf_pack(input logic [63:0] s, input logic [63:0] e,
                                            input logic [6:0] pos, input logic [63:0] em,
                                            input logic [63:0] f);
    fprf_pack = s | ((e & em) << pos) | f;
  endfunction : fprf_pack

  // a carry out of the kept field bumps the exponent; base 16 shifts a digit
  always_comb
  begin
    carry_vec = sum >> nb;
    carry     = carry_vec[0];
    is_b16    = (format_i == FPRF_B16_S) || (format_i == FPRF_B16_D);
    is_ieee   = (format_i == FPRF_IEEE_S) || (format_i == FPRF_IEEE_D);
    mfin      = carry ? (is_b16 ? (sum >> 4) : (sum >> 1)) : sum;
    eb        = 15'(exp_i) + 15'(carry) + FPRF_BIAS[format_i];
    // binary formats drop the hidden bit, base 16 keeps every digit
    fmask     = is_b16 ? ((64'h1 << nb) - 64'h1)
                       : ((64'h1 << (nb - 7'h1)) - 64'h1);
    frac      = {6'h0, mfin} & fmask;
    emask     = (64'h1 << FPRF_EXP_WID[format_i]) - 64'h1;
    sbit      = {63'h0, sign_i} << FPRF_SIGN_POS[format_i];
    int_mag   = sum[31:0];
    away      = (round_mode_select_i == FPRF_RND_NEAR_EVEN) ||
                (round_mode_select_i == FPRF_RND_NEAR_MAG) ||
                (round_mode_select_i == FPRF_RND_AWAY) ||
                ((round_mode_select_i == FPRF_RND_PLUS) && !sign_i) ||
                ((round_mode_select_i == FPRF_RND_MINUS) && sign_i);
  end

  // result selection; special cases take priority over the normal pack
  always_comb
  begin
    next_valid     = valid_i;
    next_illegal   = valid_i && (round_mode_select_i > FPRF_RND_AWAY);
    next_overflow  = 1'b0;
    next_underflow = 1'b0;
    next_inexact   = rnd_inexact;
    next_result    = 64'h0;
    if (format_i == FPRF_INT)
    begin
      // product rounded to 32 bits, two's complement out
      next_overflow = carry;
      next_result   = {32'h0, sign_i ? (32'h0 - int_mag) : int_mag};
    end
    else if (zero_i)
    begin
      // only ieee keeps a signed zero; base 16 true zero is positive
      next_inexact = 1'b0;
      next_result  = is_ieee ? sbit : 64'h0;
    end
    else if (eb > FPRF_EMAX[format_i])
    begin
      next_overflow = 1'b1;
      next_inexact  = 1'b1;
      if (is_ieee && trap_enable_i)
      begin
        // wrapped exponent, still in the chosen destination width
        next_result = fprf_pack(sbit, 64'(eb - ((format_i == FPRF_IEEE_S) ? FPRF_WRAP_S
                                : FPRF_WRAP_D)), FPRF_EXP_POS[format_i], emask,
                                frac);
      end
      else if (is_ieee && away)
      begin
        next_result = fprf_pack(sbit, emask, FPRF_EXP_POS[format_i], emask, 64'h0);
      end
      else
      begin
        // largest finite magnitude; non-ieee formats have no infinity
        next_result = fprf_pack(sbit, 64'(FPRF_EMAX[format_i]), FPRF_EXP_POS[format_i],
                                emask, fmask);
      end
    end
    else if (eb < FPRF_EMIN[format_i])
    begin
      // flush to zero; denormals are not produced
      next_underflow = 1'b1;
      next_inexact   = 1'b1;
      next_result    = is_ieee ? sbit : 64'h0;
    end
    else
    begin
      next_result = fprf_pack(sbit, 64'(eb), FPRF_EXP_POS[format_i], emask,
                              frac);
    end
  end

  // ---------------------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      valid_o        <= 1'b0;
      result_o       <= 64'h0;
      overflow_o     <= 1'b0;
      underflow_o    <= 1'b0;
      inexact_o      <= 1'b0;
      illegal_mode_o <= 1'b0;
    end
    else
    begin
      valid_o        <= next_valid;
      result_o       <= next_result;
      overflow_o     <= next_overflow;
      underflow_o    <= next_underflow;
      inexact_o      <= next_inexact;
      illegal_mode_o <= next_illegal;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  property p_illegal_mode;
    @(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (round_mode_select_i > 3'h5) |=> illegal_mode_o && valid_o;
  endproperty
  a_illegal_mode: assert property (p_illegal_mode)
    else $error("illegal mode not flagged");

  property p_near_even_tie;
    @(posedge sys_clk_i) disable iff (reset_i)
    (round_mode_select_i == FPRF_RND_NEAR_EVEN) && rnd && !stk |-> (inc == sig[0]);
  endproperty
  a_near_even_tie: assert property (p_near_even_tie)
    else $error("tie not sent to even");

  property p_minus;
    @(posedge sys_clk_i) disable iff (reset_i)
    (round_mode_select_i == FPRF_RND_MINUS) |-> (inc == (sign_i && (rnd || stk)));
  endproperty
  a_minus: assert property (p_minus)
    else $error("toward minus wrong");

  property p_plus;
    @(posedge sys_clk_i) disable iff (reset_i)
    (round_mode_select_i == FPRF_RND_PLUS) |-> (inc == (!sign_i && (rnd || stk)));
  endproperty
  a_plus: assert property (p_plus)
    else $error("toward plus wrong");

  property p_zero_mode;
    @(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (round_mode_select_i == FPRF_RND_ZERO) |-> (sum[56:0] == sig);
  endproperty
  a_zero_mode: assert property (p_zero_mode)
    else $error("toward zero changed value");

  property p_near_mag;
    @(posedge sys_clk_i) disable iff (reset_i)
    (round_mode_select_i == FPRF_RND_NEAR_MAG) && rnd |-> inc;
  endproperty
  a_near_mag: assert property (p_near_mag)
    else $error("tie not sent to larger magnitude");

  property p_away;
    @(posedge sys_clk_i) disable iff (reset_i)
    (round_mode_select_i == FPRF_RND_AWAY) |-> (inc == (rnd || stk));
  endproperty
  a_away: assert property (p_away)
    else $error("away from zero wrong");

  property p_mixed_format;
    @(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (format_i == FPRF_B16_D) && (round_mode_select_i == FPRF_RND_NEAR_EVEN)
      |=> valid_o && !illegal_mode_o;
  endproperty
  a_mixed_format: assert property (p_mixed_format)
    else $error("mode refused for format");

  property p_single_width;
    @(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (format_i == FPRF_IEEE_S) |=> (result_o[63:32] == 32'h0);
  endproperty
  a_single_width: assert property (p_single_width)
    else $error("single result widened");

  property p_trap_narrow;
    @(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (format_i == FPRF_IEEE_S) && trap_enable_i && !zero_i &&
      (eb > FPRF_EMAX[0]) |=> overflow_o && inexact_o &&
      (result_o[30:23] == $past(eb[7:0]) - 8'hc0);
  endproperty
  a_trap_narrow: assert property (p_trap_narrow)
    else $error("trapped overflow result wrong");

  property p_b16_layout;
    @(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (format_i == FPRF_B16_D) && !zero_i && (eb >= 15'sh0) && (eb <= 15'sh7f)
      |=> (result_o[62:56] == $past(eb[6:0])) && (result_o[63] == $past(sign_i));
  endproperty
  a_b16_layout: assert property (p_b16_layout)
    else $error("base-16 double layout wrong");

  property p_b16_zero;
    @(posedge sys_clk_i) disable iff (reset_i)
    valid_i && is_b16 && zero_i |=> (result_o == 64'h0);
  endproperty
  a_b16_zero: assert property (p_b16_zero)
    else $error("base-16 zero not positive");

  property p_alt_d_layout;
    @(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (format_i == FPRF_ALT_D) && !zero_i && (eb >= 15'sh1) && (eb <= 15'shff)
      |=> (result_o[62:55] == $past(eb[7:0])) && (result_o[63] == $past(sign_i));
  endproperty
  a_alt_d_layout: assert property (p_alt_d_layout)
    else $error("alternate D layout wrong");

  c_trap_overflow: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    valid_i && is_ieee && trap_enable_i && next_overflow);
  c_even_tie: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (round_mode_select_i == FPRF_RND_NEAR_EVEN) && rnd && !stk);
  c_int_round: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (format_i == FPRF_INT) && inc);
  c_alt_g: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    valid_i && (format_i == FPRF_ALT_G) && carry);

endmodule : fprf_round_format

`default_nettype wire

// >>> fprf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// host side: hands one operation per cycle to the rounding unit
// -----------------------------------------------------------------------------
module fprf_host_model
  import fprf_pkg::*;
(
  input  wire logic               sys_clk_i,
  output logic                    valid_o,
  output logic [2:0]              round_mode_select_o,
  output logic [2:0]              format_o,
  output logic                    sign_o,
  output logic                    zero_o,
  output logic signed [12:0]      exp_o,
  output logic [63:0]             mant_o,
  output logic                    sticky_o,
  output logic                    trap_enable_o
);
  // quiet bus at time zero
  initial
  begin
    valid_o = 1'b0;
    round_mode_select_o = 3'h0;
    format_o = 3'h0;
    {sign_o, zero_o, sticky_o, trap_enable_o} = 4'h0;
    exp_o = 13'sh0000;
    mant_o = 64'h0;
  end

  // one operation, launched just after an edge and held for one cycle
  task automatic issue(input logic [2:0] m, input logic [2:0] f, input logic s,
                       input logic z, input logic signed [12:0] e,
                       input logic [63:0] mt, input logic st, input logic tr);
    @(posedge sys_clk_i);
    #2;
    valid_o = 1'b1;
    round_mode_select_o = m;
    format_o = f;
    sign_o = s;
    zero_o = z;
    exp_o = e;
    mant_o = mt;
    sticky_o = st;
    trap_enable_o = tr;
  endtask : issue

  // idle cycle; operands flip so stale values never look meaningful
  task automatic idle();
    @(posedge sys_clk_i);
    #2;
    valid_o = 1'b0;
    mant_o = ~mant_o;
    exp_o = ~exp_o;
  endtask : idle
endmodule : fprf_host_model
`default_nettype wire

// >>> fp_rounding_format_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define FPRF_CHECK(act, exp) \
  begin tests_run++; if ((act) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got %h want %h", $time, act, exp); end end
module fp_rounding_format_unit_bench;
  import fprf_pkg::*;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic               sys_clk;
  logic               reset;
  logic               valid_i, sign_i, zero_i, sticky_i, trap_i;
  logic [2:0]         mode_i, fmt_i;
  logic signed [12:0] exp_i;
  logic [63:0]        mant_i, result;
  logic               valid_o, ovf, unf, inx, ill;
  logic               vin, rin;
  logic [67:0]        want, exp_q[$];
  int                 seed, fail_count, tests_run;

  fprf_host_model host_inst (.sys_clk_i(sys_clk), .valid_o(valid_i),
    .round_mode_select_o(mode_i), .format_o(fmt_i), .sign_o(sign_i), .zero_o(zero_i),
    .exp_o(exp_i), .mant_o(mant_i), .sticky_o(sticky_i), .trap_enable_o(trap_i));
  fprf_round_format fprf_round_format_inst (.sys_clk_i(sys_clk), .reset_i(reset),
    .valid_i(valid_i), .round_mode_select_i(mode_i), .format_i(fmt_i), .sign_i(sign_i),
    .zero_i(zero_i), .exp_i(exp_i), .mant_i(mant_i), .sticky_i(sticky_i),
    .trap_enable_i(trap_i), .valid_o(valid_o), .result_o(result), .overflow_o(ovf),
    .underflow_o(unf), .inexact_o(inx), .illegal_mode_o(ill));

  // ---------------------------------------------------------------------------
  // reference: flags {ovf, unf, inx, ill} then packed word
  // ---------------------------------------------------------------------------
  function automatic logic [67:0] ref_op(input logic [2:0] m, input logic [2:0] f,
      input logic s, input logic z, input logic signed [12:0] e,
      input logic [63:0] mt, input logic sti, input logic tr);
    int                 n;
    int                 pos;
    logic [64:0]        sum;
    logic               rb, st, inc, cy, ix, ov, away;
    logic signed [14:0] be;
    logic [63:0]        fm, em, sb, w;
    logic [31:0]        iv;
    n = int'(FPRF_NBITS[f]);
    pos = int'(FPRF_EXP_POS[f]);
    fm = (64'h1 << pos) - 64'h1;
    em = (64'h1 << FPRF_EXP_WID[f]) - 64'h1;
    sb = 64'(s) << FPRF_SIGN_POS[f];
    rb = mt[63-n];
    st = sti | ((mt << (n + 1)) != 64'h0);
    ix = rb | st;
    case (m)
      3'h0: inc = rb & (st | mt[64-n]);
      3'h1: inc = ix & s;
      3'h2: inc = ix & ~s;
      3'h4: inc = rb;
      3'h5: inc = ix;
      default: inc = 1'b0;
    endcase
    sum = 65'(mt >> (64 - n)) + 65'(inc);
    cy = sum[n];
    if (f == FPRF_INT)
    begin
      iv = s ? 32'h0 - sum[31:0] : sum[31:0];
      return {cy, 1'b0, ix, m > 3'h5, 32'h0, iv};
    end
    if (z)
      return {3'b000, m > 3'h5, (f < 3'h2) ? sb : 64'h0};
    // a carry renormalises by one binary place or one base-16 digit
    if (cy)
      sum = (f == FPRF_B16_S || f == FPRF_B16_D) ? sum >> 4 : sum >> 1;
    be = e + $signed({1'b0, cy}) + FPRF_BIAS[f];
    ov = be > FPRF_EMAX[f];
    // below the smallest normal: flush, only ieee keeps its sign
    if (be < FPRF_EMIN[f])
      return {2'b01, 1'b1, m > 3'h5, (f < 3'h2) ? sb : 64'h0};
    away = m == 3'h0 || m == 3'h4 || m == 3'h5 || (m == 3'h2 && !s) || (m == 3'h1 && s);
    if (ov && f < 3'h2 && tr)
      be = be - ((f == 3'h0) ? 15'sd192 : 15'sd1536);
    else if (ov && f < 3'h2 && away)
    begin
      be = FPRF_EMAX[f] + 15'sd1;
      sum = 65'h0;
    end
    else if (ov)
    begin
      be = FPRF_EMAX[f];
      sum = '1;
    end
    w = sb | ((64'(be) & em) << pos) | (sum[63:0] & fm);
    return {ov, 1'b0, ix | ov, m > 3'h5, w};
  endfunction : ref_op

  // queue the expectation, then hand the operation to the host
  task automatic run_op(input logic [2:0] m, input logic [2:0] f, input logic s,
      input logic z, input logic signed [12:0] e, input logic [63:0] mt,
      input logic st, input logic tr);
    exp_q.push_back(ref_op(m, f, s, z, e, mt, st, tr));
    host_inst.issue(m, f, s, z, e, mt, st, tr);
  endtask : run_op

  // ---------------------------------------------------------------------------
  // clock, monitor, verdict
  // ---------------------------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;

  // outputs stand one cycle, so look right after each edge settles
  always @(posedge sys_clk)
  begin
    vin = valid_i;
    rin = reset;
    #1;
    `FPRF_CHECK(valid_o, vin & ~rin)
    if (valid_o === 1'b1 && exp_q.size() > 0)
    begin
      want = exp_q.pop_front();
      `FPRF_CHECK(result, want[63:0])
      `FPRF_CHECK({ovf, unf, inx, ill}, want[67:64])
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // watchdog well past the few thousand cycles the sequence needs
  initial
  begin
    #(25 * 20000);
    fail_count++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin : main
    logic [2:0]  f;
    logic [63:0] mt;
    int          n;
    sys_clk = 1'b0;
    reset = 1'b1;
    seed = 6057;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    // ties, odd ties and carry-out for every mode and both signs
    for (int k = 0; k < 8; k++)
      if (k == 0 || k == 3 || k == 6 || k == 7)
        for (int p = 0; p < 3; p++)
          for (int m = 0; m < 16; m++)
          begin
            f = 3'(k);
            n = int'(FPRF_NBITS[f]);
            mt = (p == 2) ? ~64'h0 << (63 - n) :
                 (64'h1 << 63) | (64'(p) << (64 - n)) | (64'h1 << (63 - n));
            run_op(3'(m >> 1), f, m[0], 1'b0, 13'sd3, mt, 1'b0, 1'b0);
          end
    // overflow, trapped and untrapped, every mode
    // single exponent picked so the wrapped field lands back in range
    for (int k = 0; k < 128; k++)
      run_op(3'(k >> 4), (k[1:0] == 2'h2) ? FPRF_B16_D : 3'(k[1:0] & 2'h1), k[2],
             1'b0, (k[1:0] == 2'h0) ? 13'sd150 : 13'sd1100, 64'hc000_0000_0000_1234,
             1'b0, k[3]);
    // zero in every floating format carries the right sign
    for (int k = 0; k < 7; k++)
      run_op(3'h0, 3'(k), 1'b1, 1'b1, 13'sd0, 64'h0, 1'b0, 1'b0);
    // exponent far below range flushes every floating format; base 16 zero stays positive
    for (int k = 0; k < 7; k++)
      run_op(3'(k % 6), 3'(k), k[0], 1'b0, -13'sd1200, 64'h8000_0000_0000_0001, 1'b0,
             1'b0);
    host_inst.idle();
    host_inst.idle();
    // mid-run reset while idle
    @(posedge sys_clk);
    #2;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    // random traffic with occasional gaps
    for (int k = 0; k < 1500; k++)
    begin
      if ($random(seed) % 4 == 0)
        host_inst.idle();
      f = 3'($random(seed));
      mt = {$random(seed), $random(seed)};
      mt[63] = (f != FPRF_INT);
      run_op(3'($random(seed)), f, 1'($random(seed)), 1'b0, 13'($random(seed) % 21),
             mt, 1'($random(seed)), 1'($random(seed)));
    end
    repeat (3) host_inst.idle();
    `FPRF_CHECK(exp_q.size(), 0)
    end_of_test();
  end
endmodule : fp_rounding_format_unit_bench
`default_nettype wire
